// ===== six_source_vectored_irq_unit.sv
// Six-source vectored interrupt unit with return stack and AHB-Lite regs
//
// How it works
// - Pin falling edge sets ext request flag
// - Ext ack calls 04H/08H, clears flag, master
// - Timer0 overflow flags bit6; ack calls 0CH
// - Timer1 flag high bit4; vector 10H
// - Tick flag high bit5; vector 14H
// - RTC flag high bit6; vector 18H
// - Ack needs enables and stack not full
// - Master cleared: new requests only latch
// - Software re-enable allows nested acknowledgement
// - Ack pushes only PC, then branches
// - Interrupt return sets master; subroutine return not
// - Requests sampled on phase-two pulse
// - Fixed priority ext0 first, RTC last
// - Master enable clear masks every source
// - Low register layout; bit 7 zero
// - High register layout; bits 3,7 zero
// - Any source request wakes halted device
// - Flags hold until ack or software clear
// - Six-level stack; full at six
//
// Implementation choice: the AHB-Lite slave port.
module six_source_vectored_irq_unit #(
  parameter int PC_W = irq_unit_pkg::PC_BITS,
  parameter int STACK_DEPTH = irq_unit_pkg::STACK_LEVELS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // External interrupt pins, active low, asynchronous
  input wire logic extIrqPinA_n,
  input wire logic extIrqPinB_n,
  // Peripheral events, one-cycle pulses on mclk
  input wire logic timer0Ovf,
  input wire logic timer1Ovf,
  input wire logic tickPulse,
  input wire logic rtcPulse,
  // Core sequencer
  input wire logic clockPhaseTwo,
  input wire logic [PC_W-1:0] pcNow,
  input wire logic callInstr,
  input wire logic subExitInstr,
  input wire logic irqExitInstr,
  output logic irqTake,
  output logic [PC_W-1:0] irqVector,
  output logic [PC_W-1:0] returnAddr,
  output logic [2:0] stackIndex,
  output logic wakeReq
);

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (STACK_DEPTH < 1 || STACK_DEPTH > 7) begin : g_bad_depth
    $error("STACK_DEPTH must be 1 to 7");
  end
  if (PC_W < 8 || PC_W > 32) begin : g_bad_pc
    $error("PC_W must be 8 to 32");
  end

  localparam logic [2:0] DEPTH = 3'(STACK_DEPTH);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] pinA;
    logic [2:0] pinB;
    logic master_irq_enable;
    logic [5:0] en;
    logic [5:0] flg;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
    logic [2:0] wp;
    logic [2:0] cnt;
    logic wrPend;
    logic wrLow;
    logic wrHigh;
    logic [31:0] rdata;
    logic take;
    logic [PC_W-1:0] vec;
    logic [PC_W-1:0] ret;
    logic wake;
  } state_s;

  state_s s_ff;
  state_s nxt_s;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Highest-priority pending source, lowest index wins
  function automatic logic [2:0] pickSrc(input logic [5:0] req);
    logic [2:0] idx;
    idx = irq_unit_pkg::SRC_RTC;
    for (int i = irq_unit_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [PC_W-1:0] vecOf(input logic [2:0] src);
    logic [7:0] v;
    case (src)
      irq_unit_pkg::SRC_EXT0: v = irq_unit_pkg::VEC_EXT0;
      irq_unit_pkg::SRC_EXT1: v = irq_unit_pkg::VEC_EXT1;
      irq_unit_pkg::SRC_T0: v = irq_unit_pkg::VEC_T0;
      irq_unit_pkg::SRC_T1: v = irq_unit_pkg::VEC_T1;
      irq_unit_pkg::SRC_TB: v = irq_unit_pkg::VEC_TB;
      default: v = irq_unit_pkg::VEC_RTC;
    endcase
    return PC_W'(v);
  endfunction

  // Circular stack pointer step, wraps at the depth
  function automatic logic [2:0] stepPtr(input logic [2:0] p,
                                         input logic up);
    logic [2:0] r;
    if (up) begin
      r = (p == DEPTH - 3'h1) ? 3'h0 : p + 3'h1;
    end else begin
      r = (p == 3'h0) ? DEPTH - 3'h1 : p - 3'h1;
    end
    return r;
  endfunction

  function automatic logic [7:0] lowByte(input logic master_irq_enable,
                                         input logic [5:0] en,
                                         input logic [5:0] flg);
    logic [7:0] b;
    b = 8'h00;
    b[irq_unit_pkg::LOW_EMI] = master_irq_enable;
    b[irq_unit_pkg::LOW_EN_EXT0] = en[irq_unit_pkg::SRC_EXT0];
    b[irq_unit_pkg::LOW_EN_EXT1] = en[irq_unit_pkg::SRC_EXT1];
    b[irq_unit_pkg::LOW_EN_T0] = en[irq_unit_pkg::SRC_T0];
    b[irq_unit_pkg::LOW_FLG_EXT0] = flg[irq_unit_pkg::SRC_EXT0];
    b[irq_unit_pkg::LOW_FLG_EXT1] = flg[irq_unit_pkg::SRC_EXT1];
    b[irq_unit_pkg::LOW_FLG_T0] = flg[irq_unit_pkg::SRC_T0];
    return b;
  endfunction

  function automatic logic [7:0] highByte(input logic [5:0] en,
                                          input logic [5:0] flg);
    logic [7:0] b;
    b = 8'h00;
    b[irq_unit_pkg::HIGH_EN_T1] = en[irq_unit_pkg::SRC_T1];
    b[irq_unit_pkg::HIGH_EN_TB] = en[irq_unit_pkg::SRC_TB];
    b[irq_unit_pkg::HIGH_EN_RTC] = en[irq_unit_pkg::SRC_RTC];
    b[irq_unit_pkg::HIGH_FLG_T1] = flg[irq_unit_pkg::SRC_T1];
    b[irq_unit_pkg::HIGH_FLG_TB] = flg[irq_unit_pkg::SRC_TB];
    b[irq_unit_pkg::HIGH_FLG_RTC] = flg[irq_unit_pkg::SRC_RTC];
    return b;
  endfunction

  // ----------------------------------------------------------------------
  // Event detection and acknowledge decision
  // ----------------------------------------------------------------------
  logic fallA;
  logic fallB;
  logic [5:0] events;
  logic [5:0] pendEn;
  logic stackFull;
  logic coreBusy;
  logic ackNow;
  logic [2:0] winner;

  // Edge detectors read only the second and third synchroniser stages
  assign fallA = s_ff.pinA[2] & ~s_ff.pinA[1];
  assign fallB = s_ff.pinB[2] & ~s_ff.pinB[1];
  assign events = {rtcPulse, tickPulse, timer1Ovf, timer0Ovf,
                   fallB, fallA};
  assign pendEn = s_ff.flg & s_ff.en;
  assign stackFull = (s_ff.cnt == DEPTH);
  // A call or return owns the stack this cycle, so the ack waits
  assign coreBusy = callInstr | subExitInstr | irqExitInstr;
  assign ackNow = clockPhaseTwo & s_ff.master_irq_enable & (|pendEn)
                  & ~stackFull & ~coreBusy;
  assign winner = pickSrc(pendEn);

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Order matters: software write, then hardware clears, then sets win
  always_comb begin
    logic [2:0] top;
    logic addrOk;
    top = stepPtr(s_ff.wp, 1'b0);
    addrOk = hsel & htrans[1] & hready;
    nxt_s = s_ff;
    nxt_s.pinA = {s_ff.pinA[1:0], extIrqPinA_n};
    nxt_s.pinB = {s_ff.pinB[1:0], extIrqPinB_n};
    nxt_s.take = 1'b0;
    // Data phase of a write lands in the addressed register
    if (s_ff.wrPend && s_ff.wrLow) begin
      nxt_s.master_irq_enable = hwdata[irq_unit_pkg::LOW_EMI];
      nxt_s.en[irq_unit_pkg::SRC_EXT0] = hwdata[irq_unit_pkg::LOW_EN_EXT0];
      nxt_s.en[irq_unit_pkg::SRC_EXT1] = hwdata[irq_unit_pkg::LOW_EN_EXT1];
      nxt_s.en[irq_unit_pkg::SRC_T0] = hwdata[irq_unit_pkg::LOW_EN_T0];
      nxt_s.flg[irq_unit_pkg::SRC_EXT0] =
        hwdata[irq_unit_pkg::LOW_FLG_EXT0];
      nxt_s.flg[irq_unit_pkg::SRC_EXT1] = hwdata[irq_unit_pkg::LOW_FLG_EXT1];
      nxt_s.flg[irq_unit_pkg::SRC_T0] = hwdata[irq_unit_pkg::LOW_FLG_T0];
    end
    if (s_ff.wrPend && s_ff.wrHigh) begin
      nxt_s.en[irq_unit_pkg::SRC_T1] = hwdata[irq_unit_pkg::HIGH_EN_T1];
      nxt_s.en[irq_unit_pkg::SRC_TB] = hwdata[irq_unit_pkg::HIGH_EN_TB];
      nxt_s.en[irq_unit_pkg::SRC_RTC] = hwdata[irq_unit_pkg::HIGH_EN_RTC];
      nxt_s.flg[irq_unit_pkg::SRC_T1] = hwdata[irq_unit_pkg::HIGH_FLG_T1];
      nxt_s.flg[irq_unit_pkg::SRC_TB] = hwdata[irq_unit_pkg::HIGH_FLG_TB];
      nxt_s.flg[irq_unit_pkg::SRC_RTC] = hwdata[irq_unit_pkg::HIGH_FLG_RTC];
    end
    // Acknowledge: push PC only, branch, drop flag and master enable
    if (ackNow) begin
      nxt_s.flg[winner] = 1'b0;
      nxt_s.master_irq_enable = 1'b0;
      nxt_s.stk[s_ff.wp] = pcNow;
      nxt_s.wp = stepPtr(s_ff.wp, 1'b1);
      nxt_s.cnt = s_ff.cnt + 3'h1;
      nxt_s.vec = vecOf(winner);
      nxt_s.take = 1'b1;
    end
    // Calls overwrite the oldest entry once the stack is full
    if (callInstr) begin
      nxt_s.stk[s_ff.wp] = pcNow;
      nxt_s.wp = stepPtr(s_ff.wp, 1'b1);
      nxt_s.cnt = stackFull ? DEPTH : s_ff.cnt + 3'h1;
    end else if (subExitInstr || irqExitInstr) begin
      nxt_s.ret = s_ff.stk[top];
      if (s_ff.cnt != 3'h0) begin
        nxt_s.wp = top;
        nxt_s.cnt = s_ff.cnt - 3'h1;
      end
    end
    // Interrupt return re-arms the master enable, beating a write
    if (irqExitInstr) begin
      nxt_s.master_irq_enable = 1'b1;
    end
    // A fresh event wins over any clear in the same cycle
    nxt_s.flg = nxt_s.flg | events;
    // Address phase capture; read data taken from the updated state
    nxt_s.wrPend = addrOk & hwrite;
    nxt_s.wrLow = addrOk & (haddr == irq_unit_pkg::ADDR_CTRL_LOW);
    nxt_s.wrHigh = addrOk & (haddr == irq_unit_pkg::ADDR_CTRL_HIGH);
    nxt_s.rdata = 32'h00000000;
    if (addrOk && !hwrite && nxt_s.wrLow) begin
      nxt_s.rdata[7:0] = lowByte(nxt_s.master_irq_enable, nxt_s.en, nxt_s.flg);
    end else if (addrOk && !hwrite && nxt_s.wrHigh) begin
      nxt_s.rdata[7:0] = highByte(nxt_s.en, nxt_s.flg);
    end
    nxt_s.wake = |nxt_s.flg;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Pins idle high, so the synchronisers reset high to avoid a false edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '0;
      s_ff.pinA <= 3'h7;
      s_ff.pinB <= 3'h7;
      s_ff.master_irq_enable <= irq_unit_pkg::CTRL_RESET[irq_unit_pkg::LOW_EMI];
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Zero wait states; every transfer answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_ff.rdata;
  assign irqTake = s_ff.take;
  assign irqVector = s_ff.vec;
  assign returnAddr = s_ff.ret;
  assign stackIndex = s_ff.cnt;
  assign wakeReq = s_ff.wake;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence ackDecided;
    ackNow;
  endsequence

  sequence ackShown;
    ##1 irqTake && !s_ff.master_irq_enable;
  endsequence

  // Timer0 is the highest enabled source still pending
  sequence ackTimer0;
    ackNow && pendEn[2:0] == 3'h4;
  endsequence

  // Pop with entries left; a call in the same cycle takes precedence
  sequence retPulse;
    (subExitInstr || irqExitInstr) && !callInstr && s_ff.cnt != 3'h0;
  endsequence

  sequence callPulse;
    callInstr && !stackFull;
  endsequence

  // Plain return with no software write of the low register
  sequence plainReturn;
    subExitInstr && !irqExitInstr && !(s_ff.wrPend && s_ff.wrLow);
  endsequence

  AST_EXT_EDGE_SETS: assert property (fallA |=> s_ff.flg[0])
    else $error("ext pin A edge did not set its flag");

  AST_ACK_CLEARS: assert property (ackDecided |-> ackShown)
    else $error("ack did not pulse take or clear master enable");

  AST_VECTOR: assert property (ackTimer0 |=>
      irqVector == PC_W'(irq_unit_pkg::VEC_T0))
    else $error("wrong service vector");

  AST_FULL_HOLDS: assert property (stackIndex == DEPTH |=> !irqTake)
    else $error("ack taken with full stack");

  AST_MASKED: assert property (!s_ff.master_irq_enable |=> !irqTake)
    else $error("ack while master enable clear");

  AST_PHASE_TWO: assert property (irqTake |-> $past(clockPhaseTwo))
    else $error("ack outside phase-two pulse");

  AST_PUSH_PC: assert property (ackNow && s_ff.cnt == 3'h2 |=>
      stackIndex == 3'h3 && s_ff.stk[$past(s_ff.wp)] == $past(pcNow))
    else $error("ack did not push the program counter");

  AST_IRQ_EXIT_INSTR_SETS: assert property (irqExitInstr |=> s_ff.master_irq_enable)
    else $error("interrupt return left master enable clear");

  AST_PRIORITY: assert property (ackNow && pendEn[0] |=>
      irqVector == PC_W'(irq_unit_pkg::VEC_EXT0))
    else $error("ext0 not given top priority");

  AST_FLAG_STICKY: assert property ($fell(s_ff.flg[5]) |->
      $past(ackNow) || $past(s_ff.wrPend && s_ff.wrHigh))
    else $error("RTC flag dropped without ack or write");

  AST_WAKE: assert property (|s_ff.flg |-> wakeReq)
    else $error("pending request did not raise wake");

  AST_WAKE_EVENT: assert property (|events |=> wakeReq)
    else $error("event did not raise wake");

  // Stack bookkeeping as seen on the index pins
  AST_DEPTH_LIMIT: assert property (stackIndex <= DEPTH)
    else $error("stack index beyond depth");

  AST_RET_POPS: assert property (retPulse |=>
      stackIndex == $past(s_ff.cnt) - 3'h1)
    else $error("return did not pop the stack");

  AST_CALL_PUSHES: assert property (callPulse |=>
      stackIndex == $past(s_ff.cnt) + 3'h1)
    else $error("call did not push the stack");

  AST_SUB_EXIT_KEEPS: assert property (plainReturn |=>
      $stable(s_ff.master_irq_enable))
    else $error("subroutine return changed master enable");

  AST_NO_BACK_TO_BACK: assert property (irqTake |=> !irqTake)
    else $error("second ack while master enable clear");

  AST_RSVD_ZERO: assert property (hrdata[31:7] == '0)
    else $error("unused read bits not zero");

endmodule // six_source_vectored_irq_unit

// ===== irq_unit_pkg.sv
// Package: register map, field layout, vectors and reset values
package irq_unit_pkg;

  // ----------------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL_LOW = 8'h0b;
  localparam logic [7:0] IDX_CTRL_HIGH = 8'h1e;
  localparam logic [31:0] ADDR_CTRL_LOW = {22'h000000, IDX_CTRL_LOW, 2'h0};
  localparam logic [31:0] ADDR_CTRL_HIGH = {22'h000000, IDX_CTRL_HIGH, 2'h0};

  // ----------------------------------------------------------------------
  // Field positions, low control register
  // ----------------------------------------------------------------------
  localparam int LOW_EMI = 0;
  localparam int LOW_EN_EXT0 = 1;
  localparam int LOW_EN_EXT1 = 2;
  localparam int LOW_EN_T0 = 3;
  localparam int LOW_FLG_EXT0 = 4;
  localparam int LOW_FLG_EXT1 = 5;
  localparam int LOW_FLG_T0 = 6;

  // ----------------------------------------------------------------------
  // Field positions, high control register
  // ----------------------------------------------------------------------
  localparam int HIGH_EN_T1 = 0;
  localparam int HIGH_EN_TB = 1;
  localparam int HIGH_EN_RTC = 2;
  localparam int HIGH_FLG_T1 = 4;
  localparam int HIGH_FLG_TB = 5;
  localparam int HIGH_FLG_RTC = 6;

  // ----------------------------------------------------------------------
  // Source numbering, which is also the priority order (0 is highest)
  // ----------------------------------------------------------------------
  localparam int NUM_SRC = 6;
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_EXT1 = 3'h1;
  localparam logic [2:0] SRC_T0 = 3'h2;
  localparam logic [2:0] SRC_T1 = 3'h3;
  localparam logic [2:0] SRC_TB = 3'h4;
  localparam logic [2:0] SRC_RTC = 3'h5;

  // ----------------------------------------------------------------------
  // Service vectors, reset values, stack
  // ----------------------------------------------------------------------
  localparam logic [7:0] VEC_EXT0 = 8'h04;
  localparam logic [7:0] VEC_EXT1 = 8'h08;
  localparam logic [7:0] VEC_T0 = 8'h0c;
  localparam logic [7:0] VEC_T1 = 8'h10;
  localparam logic [7:0] VEC_TB = 8'h14;
  localparam logic [7:0] VEC_RTC = 8'h18;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int STACK_LEVELS = 6;
  localparam int PC_BITS = 12;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// ===== core_seq_model.sv
// Core sequencer model: instruction phase-two pulse for the interrupt unit
module core_seq_model #(
  parameter int PHASE_DIV = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Phase pulse towards the interrupt unit
  output logic clockPhaseTwo
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------
  // Phase counter
  // ---------------------------------------------------------------------
  logic [7:0] phaseCnt_ff;

  // One pulse per instruction cycle; a larger divider gives a slow core
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phaseCnt_ff <= 8'h00;
      clockPhaseTwo <= 1'b0;
    end else begin
      clockPhaseTwo <= (phaseCnt_ff == 8'(PHASE_DIV - 1));
      if (phaseCnt_ff == 8'(PHASE_DIV - 1)) begin
        phaseCnt_ff <= 8'h00;
      end else begin
        phaseCnt_ff <= phaseCnt_ff + 8'h01;
      end
    end
  end
endmodule // core_seq_model

// ===== tb_top.sv
// Self-checking testbench for the six-source vectored interrupt unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  localparam logic [31:0] LOW_A = irq_unit_pkg::ADDR_CTRL_LOW;
  localparam logic [31:0] HIGH_A = irq_unit_pkg::ADDR_CTRL_HIGH;
  logic mclk, arst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, stackIndex;
  logic extIrqPinA_n, extIrqPinB_n, timer0Ovf, timer1Ovf;
  logic tickPulse, rtcPulse, clockPhaseTwo, wakeReq, irqTake;
  logic callInstr, subExitInstr, irqExitInstr;
  logic [11:0] pcNow, irqVector, returnAddr;
  logic [7:0] lowExp, highExp;
  int mismatches, totalChecks, cycleCount;

  six_source_vectored_irq_unit #(.PC_W(12), .STACK_DEPTH(6)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .extIrqPinA_n(extIrqPinA_n),
    .extIrqPinB_n(extIrqPinB_n), .timer0Ovf(timer0Ovf),
    .timer1Ovf(timer1Ovf), .tickPulse(tickPulse), .rtcPulse(rtcPulse),
    .clockPhaseTwo(clockPhaseTwo), .pcNow(pcNow), .callInstr(callInstr),
    .subExitInstr(subExitInstr), .irqExitInstr(irqExitInstr),
    .irqTake(irqTake), .irqVector(irqVector), .returnAddr(returnAddr),
    .stackIndex(stackIndex), .wakeReq(wakeReq));

  core_seq_model #(.PHASE_DIV(4)) seq_u (
    .mclk(mclk), .arst_n(arst_n), .clockPhaseTwo(clockPhaseTwo));

  // Clock and hang guard; a run needs well under a thousand cycles
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycleCount++;
    if (cycleCount >= 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Single word AHB-Lite transfer; waits on hready, timeout ends a hang
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= irq_unit_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] unused;
    ahb(1'b1, a, {24'h000000, d}, unused);
  endtask

  task automatic rdChk(input string n, input logic [31:0] a,
                       input logic [7:0] e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h00000000, v);
    check(n, v, {24'h000000, e});
  endtask

  // Bit 0/1 lower a pin for good, bits 2..5 give one-cycle events
  task automatic fire(input logic [5:0] m);
    @(posedge mclk);
    extIrqPinA_n <= extIrqPinA_n & ~m[0];
    extIrqPinB_n <= extIrqPinB_n & ~m[1];
    timer0Ovf <= m[2];
    timer1Ovf <= m[3];
    tickPulse <= m[4];
    rtcPulse <= m[5];
    @(posedge mclk);
    {timer0Ovf, timer1Ovf, tickPulse, rtcPulse} <= 4'h0;
    repeat (4) @(posedge mclk);
  endtask

  // The acknowledge pulse lasts one cycle, so every edge is looked at
  task automatic waitTake(input logic [11:0] vec, input logic [2:0] depth);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (irqTake !== 1'b1 && n < 40);
    check("irqTake", 32'(irqTake), 32'h1);
    check("irqVector", 32'(irqVector), 32'(vec));
    check("stackIndex", 32'(stackIndex), 32'(depth));
  endtask

  task automatic noTake();
    int seen;
    seen = 0;
    repeat (16) begin
      @(posedge mclk);
      if (irqTake !== 1'b0) seen++;
    end
    check("held off", 32'(seen), 32'h0);
  endtask

  task automatic popStack(input logic viaIrq, input logic [11:0] ra,
                          input logic [2:0] depth);
    @(posedge mclk);
    irqExitInstr <= viaIrq;
    subExitInstr <= ~viaIrq;
    @(posedge mclk);
    irqExitInstr <= 1'b0;
    subExitInstr <= 1'b0;
    #1;
    check("returnAddr", 32'(returnAddr), 32'(ra));
    check("stackIndex", 32'(stackIndex), 32'(depth));
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    {arst_n, hsel, hwrite, callInstr, subExitInstr, irqExitInstr} = 6'h00;
    {timer0Ovf, timer1Ovf, tickPulse, rtcPulse} = 4'h0;
    {extIrqPinA_n, extIrqPinB_n} = 2'h3;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h2;
    pcNow = 12'h000;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    check("stackIndex", 32'(stackIndex), 32'h0);
    check("wakeReq", 32'(wakeReq), 32'h0);
    rdChk("low", LOW_A, 8'h00);
    rdChk("high", HIGH_A, 8'h00);
    // Unmapped place: write ignored, reads zero, response OKAY
    wr(32'h00000040, 8'hff);
    rdChk("unmapped", 32'h00000040, 8'h00);
    check("hresp", 32'(hresp), 32'h0);
    // Every bit written with the master enable off
    wr(LOW_A, 8'hfe);
    rdChk("low", LOW_A, 8'h7e);
    wr(HIGH_A, 8'hff);
    rdChk("high", HIGH_A, 8'h77);
    check("wakeReq", 32'(wakeReq), 32'h1);
    wr(LOW_A, 8'h0e);
    wr(HIGH_A, 8'h07);
    rdChk("low", LOW_A, 8'h0e);
    check("wakeReq", 32'(wakeReq), 32'h0);
    // All six sources at once, then served one by one in priority
    fire(6'h3f);
    check("wakeReq", 32'(wakeReq), 32'h1);
    rdChk("low", LOW_A, 8'h7e);
    rdChk("high", HIGH_A, 8'h77);
    lowExp = 8'h7e;
    highExp = 8'h77;
    for (int i = 0; i < 6; i++) begin
      pcNow <= 12'h100 + 12'(i);
      wr(LOW_A, lowExp | 8'h01);
      waitTake(12'(4 * (i + 1)), 3'(i + 1));
      if (i < 3) lowExp[4 + i] = 1'b0;
      else highExp[1 + i] = 1'b0;
      rdChk("low", LOW_A, lowExp);
      rdChk("high", HIGH_A, highExp);
    end
    // Full stack holds a pending request until a return
    fire(6'h04);
    wr(LOW_A, 8'h4f);
    noTake();
    rdChk("low", LOW_A, 8'h4f);
    pcNow <= 12'h200;
    // Service code keeps its own status; only the PC comes back
    popStack(1'b1, 12'h105, 3'h5);
    waitTake(12'h00c, 3'h6);
    popStack(1'b0, 12'h200, 3'h5);
    rdChk("low", LOW_A, 8'h0e);
    // Master off: request only latches; re-enable gives a nested ack
    fire(6'h10);
    noTake();
    rdChk("high", HIGH_A, 8'h27);
    check("wakeReq", 32'(wakeReq), 32'h1);
    pcNow <= 12'h300;
    wr(LOW_A, 8'h0f);
    waitTake(12'h014, 3'h6);
    popStack(1'b1, 12'h300, 3'h5);
    rdChk("low", LOW_A, 8'h0f);
    // Plain call and subroutine return share the same stack
    @(posedge mclk);
    pcNow <= 12'h400;
    callInstr <= 1'b1;
    @(posedge mclk);
    callInstr <= 1'b0;
    popStack(1'b0, 12'h400, 3'h5);
    tally_and_finish();
  end
endmodule // tb_top
